// *** mx_pkg.sv ***
`default_nettype none
package mx_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W   = 8;          // accumulator and file width
  localparam int ADDR_W   = 7;          // file address, 0..127
  localparam int FILE_D   = 128;        // file register depth
  localparam int PRE_W    = 8;          // watchdog prescaler width
  // ---------------------------------------------------------------
  // operands and values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] DIR_A_SEL = 7'h05;  // port a direction
  localparam logic [ADDR_W-1:0] DIR_B_SEL = 7'h06;  // port b direction
  localparam logic [ADDR_W-1:0] DIR_C_SEL = 7'h07;  // port c direction
  localparam logic [DATA_W-1:0] WDOG_CLEAR = 8'h00; // watchdog after sleep
  localparam logic [PRE_W-1:0]  PRE_CLEAR = 8'h00;  // prescaler after sleep
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;  // accumulator
  localparam logic [DATA_W-1:0] DIR_RST   = 8'hFF;  // all pins input
  localparam logic              EXPIRY_RST = 1'b1;  // expiry flag
  localparam logic              PDOWN_RST  = 1'b1;  // power-down flag
  localparam logic              FLAG_RST  = 1'b0;   // carry, nibble, zero
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    no_op,
    literal_minus_acc_op,
    file_minus_acc_op,
    file_minus_acc_borrow_op,
    nibble_exchange_op,
    literal_xor_op,
    file_xor_op,
    load_direction_op,
    sleep_op
  } mx_op_t;
  typedef enum logic [1:0] {
    st_idle,
    st_exec,
    st_sleep
  } mx_state_t;
endpackage
`default_nettype wire

// *** mx_file_ram.sv ***
`timescale 1ns/10ps
`default_nettype none
module mx_file_ram #(
  parameter int DW = 8,
  parameter int AW = 7,
  parameter int DEPTH = 128
) (
  input  wire logic          sys_clk_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [DW-1:0] rd_data_out,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // cleared at load so simulation never reads unknowns; there is no reset,
  // so firmware must still write a cell before trusting its contents
  logic [DW-1:0] mem_q [DEPTH] = '{default: '0};  // file registers
  logic [DW-1:0] rd_q;           // registered read word

  // one write port, one registered read port
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_q <= mem_q[rd_addr_in];
  end

  assign rd_data_out = rd_q;
endmodule
`default_nettype wire

// *** mx_exec.sv ***
`timescale 1ns/10ps
`default_nettype none
module mx_exec #(
  parameter int PRE_W = mx_pkg::PRE_W
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rstn_in,
  input  wire logic                      op_valid_in,
  input  wire mx_pkg::mx_op_t            op_code_in,
  input  wire logic [mx_pkg::DATA_W-1:0] literal_in,
  input  wire logic [mx_pkg::ADDR_W-1:0] file_addr_in,
  input  wire logic                      dest_in,
  input  wire logic                      wake_in,
  output logic                           op_ready_out,
  output logic                           done_out,
  output logic [mx_pkg::DATA_W-1:0]      result_out,
  output logic [mx_pkg::DATA_W-1:0]      acc_out,
  output logic                           carry_out,
  output logic                           nibble_half_flag_out,
  output logic                           zero_out,
  output logic                           watchdog_expiry_flag_out,
  output logic                           power_down_flag_out,
  output logic                           sleeping_out,
  output logic [mx_pkg::DATA_W-1:0]      watchdog_counter_out,
  output logic [PRE_W-1:0]               prescaler_out,
  output logic [mx_pkg::DATA_W-1:0]      port_a_direction_out,
  output logic [mx_pkg::DATA_W-1:0]      port_b_direction_out,
  output logic [mx_pkg::DATA_W-1:0]      port_c_direction_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    mx_pkg::mx_state_t         state;   // sequencer
    mx_pkg::mx_op_t            op;      // latched operation
    logic [mx_pkg::DATA_W-1:0] lit;     // latched literal
    logic [mx_pkg::ADDR_W-1:0] addr;    // latched file address
    logic                      dest;    // latched destination bit
    logic [mx_pkg::DATA_W-1:0] acc;     // accumulator
    logic                      carry;   // carry, borrow inverse
    logic                      half;    // nibble half flag
    logic                      zero;    // zero flag
    logic                      expiry;  // watchdog expiry flag
    logic                      pdown;   // power-down flag
    logic [mx_pkg::DATA_W-1:0] wdog;    // watchdog counter
    logic [PRE_W-1:0]          pre;     // watchdog prescaler
    logic [mx_pkg::DATA_W-1:0] dir_a;   // port a direction
    logic [mx_pkg::DATA_W-1:0] dir_b;   // port b direction
    logic [mx_pkg::DATA_W-1:0] dir_c;   // port c direction
    logic [mx_pkg::DATA_W-1:0] res;     // last result
    logic                      done;    // one-cycle completion
    logic                      ready;   // accepting operations
    logic                      asleep;  // halted until wake
    logic [1:0]                wk;      // wake pin synchroniser
  } mx_core_t;

  mx_core_t                  st_q;      // registered state
  mx_core_t                  st_d;      // next state
  logic [mx_pkg::DATA_W-1:0] rd_data;   // file word for the latched address
  logic [mx_pkg::ADDR_W-1:0] rd_addr;   // file read address
  logic                      wr_en;     // file write strobe
  logic [mx_pkg::DATA_W-1:0] alu;       // operation result
  logic                      file_dst;  // result goes to the file

  // file read address: present at accept so data is ready in exec
  assign rd_addr = (st_q.state == mx_pkg::st_idle) ? file_addr_in : st_q.addr;

  // ---------------------------------------------------------------
  // file registers
  // ---------------------------------------------------------------
  mx_file_ram #(
    .DW    (mx_pkg::DATA_W),
    .AW    (mx_pkg::ADDR_W),
    .DEPTH (mx_pkg::FILE_D)
  ) u_file (
    .sys_clk_in  (sys_clk_in),
    .rd_addr_in  (rd_addr),
    .rd_data_out (rd_data),
    .wr_en_in    (wr_en),
    .wr_addr_in  (st_q.addr),
    .wr_data_in  (alu)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [mx_pkg::DATA_W-1:0] opnd;
    logic                      cin;
    logic [mx_pkg::DATA_W:0]   sum9;
    logic [4:0]                sum5;
    // subtract as opnd + ~acc + cin; carry out is the borrow inverse
    opnd = (st_q.op == mx_pkg::literal_minus_acc_op) ? st_q.lit : rd_data;
    cin = (st_q.op == mx_pkg::file_minus_acc_borrow_op) ? st_q.carry : 1'b1;
    sum9 = {1'b0, opnd} + {1'b0, ~st_q.acc} + {8'h00, cin};
    sum5 = {1'b0, opnd[3:0]} + {1'b0, ~st_q.acc[3:0]} + {4'h0, cin};
    st_d = st_q;
    st_d.done = 1'b0;
    wr_en = 1'b0;
    file_dst = 1'b0;
    alu = 8'h00;
    st_d.wk = {st_q.wk[0], wake_in};
    // watchdog runs in every state; prescaler wrap ticks the counter
    st_d.pre = st_q.pre + 1'b1;
    if (&st_q.pre) begin
      st_d.wdog = st_q.wdog + 1'b1;
    end
    case (st_q.state)
      mx_pkg::st_idle: begin
        // latch the operation; file data arrives next cycle
        if (op_valid_in && op_code_in != mx_pkg::no_op) begin
          st_d.op = op_code_in;
          st_d.lit = literal_in;
          st_d.addr = file_addr_in;
          st_d.dest = dest_in;
          st_d.state = mx_pkg::st_exec;
          st_d.ready = 1'b0;
        end
      end
      mx_pkg::st_exec: begin
        st_d.state = mx_pkg::st_idle;
        st_d.ready = 1'b1;
        st_d.done = 1'b1;
        case (st_q.op)
          mx_pkg::literal_minus_acc_op,
          mx_pkg::file_minus_acc_op,
          mx_pkg::file_minus_acc_borrow_op: begin
            alu = sum9[7:0];
            st_d.carry = sum9[8];
            st_d.half = sum5[4];
            st_d.zero = (alu == 8'h00);
            file_dst = (st_q.op != mx_pkg::literal_minus_acc_op);
          end
          mx_pkg::nibble_exchange_op: begin
            alu = {rd_data[3:0], rd_data[7:4]};
            file_dst = 1'b1;
          end
          mx_pkg::literal_xor_op: begin
            alu = st_q.acc ^ st_q.lit;
            st_d.zero = (alu == 8'h00);
          end
          mx_pkg::file_xor_op: begin
            alu = st_q.acc ^ rd_data;
            st_d.zero = (alu == 8'h00);
            file_dst = 1'b1;
          end
          mx_pkg::load_direction_op: begin
            // other operands load nothing
            alu = st_q.acc;
            if (st_q.addr == mx_pkg::DIR_A_SEL) begin
              st_d.dir_a = st_q.acc;
            end else if (st_q.addr == mx_pkg::DIR_B_SEL) begin
              st_d.dir_b = st_q.acc;
            end else if (st_q.addr == mx_pkg::DIR_C_SEL) begin
              st_d.dir_c = st_q.acc;
            end
          end
          mx_pkg::sleep_op: begin
            st_d.wdog = mx_pkg::WDOG_CLEAR;
            st_d.pre = mx_pkg::PRE_CLEAR;
            st_d.expiry = 1'b1;
            st_d.pdown = 1'b0;
            st_d.state = mx_pkg::st_sleep;
            st_d.asleep = 1'b1;
            st_d.ready = 1'b0;
          end
          default: begin
            alu = st_q.acc;
          end
        endcase
        // destination select for register operand operations
        if (file_dst && st_q.dest) begin
          wr_en = 1'b1;
        end else if (st_q.op != mx_pkg::load_direction_op &&
                     st_q.op != mx_pkg::sleep_op) begin
          st_d.acc = alu;
        end
        st_d.res = alu;
      end
      mx_pkg::st_sleep: begin
        // halted: nothing accepted until the synchronised wake pin
        if (st_q.wk[1]) begin
          st_d.state = mx_pkg::st_idle;
          st_d.ready = 1'b1;
          st_d.asleep = 1'b0;
        end
      end
      default: begin
        st_d.state = mx_pkg::st_idle;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_q <= '0;
      st_q.state <= mx_pkg::st_idle;
      st_q.op <= mx_pkg::no_op;
      st_q.acc <= mx_pkg::ACC_RST;
      st_q.carry <= mx_pkg::FLAG_RST;
      st_q.half <= mx_pkg::FLAG_RST;
      st_q.zero <= mx_pkg::FLAG_RST;
      st_q.expiry <= mx_pkg::EXPIRY_RST;
      st_q.pdown <= mx_pkg::PDOWN_RST;
      st_q.dir_a <= mx_pkg::DIR_RST;
      st_q.dir_b <= mx_pkg::DIR_RST;
      st_q.dir_c <= mx_pkg::DIR_RST;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign op_ready_out = st_q.ready;
  assign done_out = st_q.done;
  assign result_out = st_q.res;
  assign acc_out = st_q.acc;
  assign carry_out = st_q.carry;
  assign nibble_half_flag_out = st_q.half;
  assign zero_out = st_q.zero;
  assign watchdog_expiry_flag_out = st_q.expiry;
  assign power_down_flag_out = st_q.pdown;
  assign sleeping_out = st_q.asleep;
  assign watchdog_counter_out = st_q.wdog;
  assign prescaler_out = st_q.pre;
  assign port_a_direction_out = st_q.dir_a;
  assign port_b_direction_out = st_q.dir_b;
  assign port_c_direction_out = st_q.dir_c;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  logic ex;  // executing this cycle
  assign ex = (st_q.state == mx_pkg::st_exec);

  a_lit_sub_value: assert property (
    ex && st_q.op == mx_pkg::literal_minus_acc_op |=>
      st_q.acc == 8'($past(st_q.lit) - $past(st_q.acc)))
    else $error("literal subtract result wrong");
  a_lit_sub_flags: assert property (
    ex && st_q.op == mx_pkg::literal_minus_acc_op |=>
      st_q.carry == ($past(st_q.acc) <= $past(st_q.lit)) &&
      st_q.half == ($past(st_q.acc[3:0]) <= $past(st_q.lit[3:0])))
    else $error("literal subtract flags wrong");
  a_file_sub_flags: assert property (
    ex && st_q.op == mx_pkg::file_minus_acc_op |=>
      st_q.carry == ($past(st_q.acc) <= $past(rd_data)))
    else $error("file subtract borrow wrong");
  a_file_sub_value: assert property (
    ex && st_q.op == mx_pkg::file_minus_acc_op |->
      alu == 8'(rd_data - st_q.acc))
    else $error("file subtract result wrong");
  a_dest_file: assert property (
    ex && st_q.dest && st_q.op == mx_pkg::file_xor_op |-> wr_en ##1 $stable(st_q.acc))
    else $error("destination select wrong");
  a_borrow_value: assert property (
    ex && st_q.op == mx_pkg::file_minus_acc_borrow_op |->
      alu == 8'(rd_data - st_q.acc - {7'h00, ~st_q.carry}))
    else $error("borrow subtract wrong");
  a_swap_flags: assert property (
    ex && st_q.op == mx_pkg::nibble_exchange_op |=>
      $stable(st_q.carry) && $stable(st_q.half) && $stable(st_q.zero))
    else $error("nibble exchange touched flags");
  a_xor_lit: assert property (
    ex && st_q.op == mx_pkg::literal_xor_op |=>
      st_q.acc == ($past(st_q.acc) ^ $past(st_q.lit)) && $stable(st_q.carry))
    else $error("literal xor wrong");
  a_dir_load: assert property (
    ex && st_q.op == mx_pkg::load_direction_op && st_q.addr == mx_pkg::DIR_B_SEL |=>
      st_q.dir_b == $past(st_q.acc) && $stable(st_q.dir_a))
    else $error("direction load wrong");
  a_sleep_entry: assert property (
    ex && st_q.op == mx_pkg::sleep_op |=>
      st_q.wdog == 8'h00 && st_q.pre == 8'h00 && st_q.expiry && !st_q.pdown)
    else $error("sleep did not clear watchdog");
  a_sleep_halt: assert property (
    sleeping_out && !st_q.wk[1] |=> sleeping_out && !done_out && !op_ready_out)
    else $error("executed while asleep");
  a_zero_flag: assert property (
    ex && st_q.op == mx_pkg::file_xor_op |=> st_q.zero == ($past(alu) == 8'h00))
    else $error("zero flag wrong");

  c_borrow_sub: cover property (ex && st_q.op == mx_pkg::file_minus_acc_borrow_op && !st_q.carry);
  c_file_write: cover property (wr_en);
  c_sleep_wake: cover property (sleeping_out ##[1:20] !sleeping_out);
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ---------------------------------------------------------------
  // stimulus and design hookup
  // ---------------------------------------------------------------
  logic                        sys_clk;       // 250 MHz core clock
  logic                        rstn;          // synchronous reset, low
  logic                        op_valid;      // request strobe
  mx_pkg::mx_op_t              op_code;       // requested operation
  logic [mx_pkg::DATA_W-1:0]   literal;       // literal k
  logic [mx_pkg::ADDR_W-1:0]   file_addr;     // file address or operand
  logic                        dest;          // 0 acc, 1 file
  logic                        wake;          // wake pin
  logic                        op_ready, done, carry, nib, zero, expiry, pdown, sleeping;
  logic [7:0]                  result, acc, wdog, pre, dir_a, dir_b, dir_c;
  int                          num_errors;    // mismatches seen
  int                          checks;        // comparisons made
  int                          seed;          // random seed
  // behavioural model state, plain integers
  int m_acc, m_c, m_half, m_z, m_res, m_exp, m_pdn;
  int m_file [128];
  int m_dir [3];
  int addrs [4];

  mx_exec DUT (
    .sys_clk_in               (sys_clk),
    .rstn_in                  (rstn),
    .op_valid_in              (op_valid),
    .op_code_in               (op_code),
    .literal_in               (literal),
    .file_addr_in             (file_addr),
    .dest_in                  (dest),
    .wake_in                  (wake),
    .op_ready_out             (op_ready),
    .done_out                 (done),
    .result_out               (result),
    .acc_out                  (acc),
    .carry_out                (carry),
    .nibble_half_flag_out     (nib),
    .zero_out                 (zero),
    .watchdog_expiry_flag_out (expiry),
    .power_down_flag_out      (pdown),
    .sleeping_out             (sleeping),
    .watchdog_counter_out     (wdog),
    .prescaler_out            (pre),
    .port_a_direction_out     (dir_a),
    .port_b_direction_out     (dir_b),
    .port_c_direction_out     (dir_c)
  );

  // clock: inverted every half period
  always #2 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  // compare one design value with the model, case equality so x fails
  task automatic cmp(input logic [7:0] got, input int exp, input string what);
    checks++;
    if (got !== exp[7:0]) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp[7:0]);
    end
  endtask

  // accumulator, result, flags and port directions against the model
  task automatic check_all();
    cmp(acc, m_acc, "accumulator");
    cmp(result, m_res, "result");
    cmp({7'h00, carry}, m_c, "carry");
    cmp({7'h00, nib}, m_half, "nibble flag");
    cmp({7'h00, zero}, m_z, "zero flag");
    cmp({7'h00, expiry}, m_exp, "expiry flag");
    cmp({7'h00, pdown}, m_pdn, "power-down flag");
    cmp(dir_a, m_dir[0], "port a direction");
    cmp(dir_b, m_dir[1], "port b direction");
    cmp(dir_c, m_dir[2], "port c direction");
  endtask

  // drive one request from a falling edge, wait for the done pulse
  task automatic issue(input mx_pkg::mx_op_t op, input int k, input int a, input int d);
    int n;
    op_valid = 1'b1;
    op_code = op;
    literal = k[7:0];
    file_addr = a[6:0];
    dest = d[0];
    @(negedge sys_clk);
    op_valid = 1'b0;
    n = 0;
    // bounded wait: the pulse is due one cycle after this point
    while (done !== 1'b1 && n < 6) begin
      @(negedge sys_clk);
      n++;
    end
    checks++;
    if (n == 6) begin
      num_errors++;
      $display("MISMATCH at %0t: no done pulse", $time);
    end
  endtask

  // model one operation, run it, compare the modelled outputs at the done cycle
  task automatic run_op(input mx_pkg::mx_op_t op, input int k, input int a, input int d);
    int f, r, b, tgt;
    f = m_file[a];
    tgt = 0;
    r = m_res;
    case (op)
      mx_pkg::literal_minus_acc_op: begin
        r = (k - m_acc) & 255;
        m_c = (m_acc <= k);
        m_half = ((m_acc & 15) <= (k & 15));
        m_acc = r;
      end
      mx_pkg::file_minus_acc_op: begin
        r = (f - m_acc) & 255;
        m_c = (m_acc <= f);
        m_half = ((m_acc & 15) <= (f & 15));
        tgt = 1;
      end
      mx_pkg::file_minus_acc_borrow_op: begin
        // inverted carry acts as the borrow in
        b = 1 - m_c;
        m_c = ((f - m_acc - b) >= 0);
        m_half = (((f & 15) - (m_acc & 15) - b) >= 0);
        r = (f - m_acc - b) & 255;
        tgt = 1;
      end
      mx_pkg::nibble_exchange_op: begin
        r = ((f & 15) << 4) | (f >> 4);
        tgt = 1;
      end
      mx_pkg::literal_xor_op: begin
        r = m_acc ^ (k & 255);
        m_acc = r;
      end
      mx_pkg::file_xor_op: begin
        r = m_acc ^ f;
        tgt = 1;
      end
      mx_pkg::load_direction_op: begin
        r = m_acc;
        // operands outside 5..7 select no register
        if (a >= 5 && a <= 7) m_dir[a-5] = m_acc;
      end
      default: begin
        r = 0;
        m_exp = 1;
        m_pdn = 0;
      end
    endcase
    // zero follows only the subtracts and xors
    if (op != mx_pkg::nibble_exchange_op && op != mx_pkg::load_direction_op && op != mx_pkg::sleep_op)
      m_z = (r == 0);
    if (tgt == 1 && d == 1) m_file[a] = r;
    else if (tgt == 1) m_acc = r;
    m_res = r;
    issue(op, k, a, d);
    check_all();
  endtask

  // learn an unreset file cell once, then clear it to a known value
  task automatic learn(input int a);
    run_op(mx_pkg::literal_xor_op, m_acc, 0, 0);
    issue(mx_pkg::file_xor_op, 0, a, 0);
    checks++;
    if ($isunknown(result)) begin
      num_errors++;
      $display("MISMATCH at %0t: file cell %0d unreadable", $time, a);
    end
    m_file[a] = result;
    m_acc = m_file[a];
    m_res = m_acc;
    m_z = (m_acc == 0);
    check_all();
    run_op(mx_pkg::file_xor_op, 0, a, 1);
  endtask

  // closing: counts, verdict, end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i, op, a, k;
    sys_clk = 1'b0;
    rstn = 1'b0;
    op_valid = 1'b0;
    op_code = mx_pkg::no_op;
    literal = 8'h00;
    file_addr = 7'h00;
    dest = 1'b0;
    wake = 1'b0;
    num_errors = 0;
    checks = 0;
    seed = 32'hCE77;
    m_acc = 0;
    m_c = 0;
    m_half = 0;
    m_z = 0;
    m_res = 0;
    m_exp = 1;
    m_pdn = 1;
    m_dir = '{255, 255, 255};
    addrs = '{0, 127, 33, 90};
    repeat (6) @(negedge sys_clk);
    check_all();
    cmp({7'h00, op_ready}, 1, "ready after reset");
    rstn = 1'b1;
    $display("test reset done");
    // prime the cells used below; boundary addresses included
    for (i = 0; i < 4; i++) learn(addrs[i]);
    $display("test file priming done");
    // literal subtract boundaries, acc equals literal and exceeds it
    run_op(mx_pkg::literal_minus_acc_op, 8'h00, 0, 0);
    run_op(mx_pkg::literal_minus_acc_op, 8'h10, 0, 0);
    run_op(mx_pkg::literal_minus_acc_op, 8'h0F, 0, 0);
    // each direction operand, plus one that selects nothing
    for (i = 4; i <= 7; i++) begin
      run_op(mx_pkg::literal_xor_op, 8'hA0 + i, 0, 0);
      run_op(mx_pkg::load_direction_op, 0, i, 0);
    end
    $display("test directed ops done");
    // random back-to-back traffic over all execute operations except sleep
    for (i = 0; i < 150; i++) begin
      op = 1 + ($unsigned($random(seed)) % 7);
      k = $random(seed) & 255;
      a = addrs[$unsigned($random(seed)) % 4];
      if (op == 7) a = 4 + ($unsigned($random(seed)) % 4);
      run_op(mx_pkg::mx_op_t'(op), k, a, $random(seed) & 1);
    end
    $display("test random ops done");
    // sleep: watchdog cleared, expiry set, power-down cleared, requests refused until wake
    run_op(mx_pkg::sleep_op, 0, 0, 0);
    cmp(wdog, 0, "watchdog counter");
    cmp(pre, 0, "prescaler");
    cmp({7'h00, sleeping}, 1, "sleeping");
    op_valid = 1'b1;
    op_code = mx_pkg::literal_xor_op;
    literal = 8'h5A;
    for (i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      cmp({7'h00, done}, 0, "done while asleep");
      cmp(pre, i + 1, "prescaler running from zero");
    end
    op_valid = 1'b0;
    check_all();
    wake = 1'b1;
    i = 0;
    while (sleeping !== 1'b0 && i < 8) begin
      @(negedge sys_clk);
      i++;
    end
    wake = 1'b0;
    cmp({7'h00, sleeping}, 0, "woken");
    @(negedge sys_clk);
    run_op(mx_pkg::literal_xor_op, 8'h3C, 0, 0);
    $display("test sleep done");
    report_and_stop();
  end

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(4 * 20000);
    num_errors++;
    $display("MISMATCH at %0t: run timed out", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
